// *** src/mau_cfg.svh ***
`ifndef MAU_CFG_SVH
`define MAU_CFG_SVH

// register word offsets on the peripheral word bus
`define MAU_OFF_MUL_U    16'h0130
`define MAU_OFF_MUL_S    16'h0132
`define MAU_OFF_ACC_U    16'h0134
`define MAU_OFF_ACC_S    16'h0136
`define MAU_OFF_OPB      16'h0138
`define MAU_OFF_RES_LO   16'h013a
`define MAU_OFF_RES_HI   16'h013c
`define MAU_OFF_SUM_EXT  16'h013e

// reset and fill values
`define MAU_RST_WORD     16'h0000
`define MAU_EXT_ONES     16'hffff
`define MAU_EXT_ONE      16'h0001
`define MAU_BYTE_HI_ZERO 8'h00

// field positions
`define MAU_WORD_MSB     15
`define MAU_BYTE_MSB     7
`define MAU_RES_MSB      31

`endif

// *** src/mau_pkg.sv ***
package mau_pkg;

  typedef enum logic [1:0] {
    MAU_MUL_U,
    MAU_MUL_S,
    MAU_ACC_U,
    MAU_ACC_S
  } mau_mode_t;

endpackage : mau_pkg

// *** src/mau_mult.sv ***
`timescale 1ns/1ps
`default_nettype none

// full product of two operands, signed or unsigned
module mau_mult #(
  parameter int W = 16
) (
  input  wire logic [W-1:0]   op_a,
  input  wire logic [W-1:0]   op_b,
  input  wire logic           signed_op,
  output logic      [2*W-1:0] product
);

  logic signed [W:0]     ext_a;
  logic signed [W:0]     ext_b;
  logic signed [2*W+1:0] full;

  always_comb begin
    ext_a   = {signed_op & op_a[W-1], op_a};
    ext_b   = {signed_op & op_b[W-1], op_b};
    full    = ext_a * ext_b;
    product = full[2*W-1:0];
  end

endmodule : mau_mult

`default_nettype wire

// *** src/mau_acc.sv ***
`timescale 1ns/1ps
`default_nettype none

// adds a product to the held result, reports carry
module mau_acc #(
  parameter int W = 32
) (
  input  wire logic [W-1:0] acc_in,
  input  wire logic [W-1:0] addend,
  output logic      [W-1:0] sum,
  output logic              carry
);

  logic [W:0] wide;

  always_comb begin
    wide  = {1'b0, acc_in} + {1'b0, addend};
    sum   = wide[W-1:0];
    carry = wide[W];
  end

endmodule : mau_acc

`default_nettype wire

// *** src/mau_top.sv ***
// What this block does
// - multiplies 16 or 8 bit operands, full product
// - unsigned or signed multiply chosen by address
// - accumulate modes add product to held result
// - result ready on next access, no waits
// - first operand at 0x0134 selects unsigned accumulate
// - first operand at 0x0136 selects signed accumulate
`timescale 1ns/1ps
`default_nettype none
`include "mau_cfg.svh"

module mau_top #(
  parameter int DW = 16
) (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic [15:0]   bus_addr,
  input  wire logic          bus_wr,
  input  wire logic          bus_byte,
  input  wire logic          bus_rd,
  input  wire logic [DW-1:0] bus_wdata,
  output logic      [DW-1:0] bus_rdata,
  output logic               bus_hit
);

  mau_pkg::mau_mode_t mode_reg;
  mau_pkg::mau_mode_t mode_next;
  logic [DW-1:0]      op_a_reg;
  logic [DW-1:0]      op_a_next;
  logic [DW-1:0]      op_b_reg;
  logic [DW-1:0]      op_b_next;
  logic [DW-1:0]      res_lo_reg;
  logic [DW-1:0]      res_lo_next;
  logic [DW-1:0]      res_hi_reg;
  logic [DW-1:0]      res_hi_next;
  logic [DW-1:0]      ext_reg;
  logic [DW-1:0]      ext_next;
  logic [DW-1:0]      rdata_reg;
  logic [DW-1:0]      rdata_next;
  logic               hit_reg;
  logic               hit_next;

  logic [15:0]        word_addr;
  logic [DW-1:0]      wr_word;
  logic [2*DW-1:0]    product;
  logic [2*DW-1:0]    acc_sum;
  logic               acc_carry;
  logic               is_signed;
  logic               mapped;
  logic               sel_op_a;
  logic               sel_op_b;
  logic               sel_res_lo;
  logic               sel_res_hi;
  mau_pkg::mau_mode_t sel_mode;
  logic [2*DW-1:0]    result_word;
  logic [DW-1:0]      ext_word;
  logic [DW-1:0]      read_word;
  logic [2*DW-1:0]    acc_base;

  // byte write loads an 8 bit operand, high byte cleared
  always_comb begin
    word_addr = {bus_addr[15:1], 1'b0};
    if (bus_byte) begin
      wr_word = {`MAU_BYTE_HI_ZERO, bus_wdata[`MAU_BYTE_MSB:0]};
    end else begin
      wr_word = bus_wdata;
    end
  end

  // signed operands for the signed modes only
  always_comb begin
    case (mode_reg)
      mau_pkg::MAU_MUL_S: begin
        is_signed = 1'b1;
      end
      mau_pkg::MAU_ACC_S: begin
        is_signed = 1'b1;
      end
      default: begin
        is_signed = 1'b0;
      end
    endcase
  end

  // held result as accumulator base
  always_comb begin
    acc_base = {res_hi_reg, res_lo_reg};
  end

  mau_mult #(
    .W (DW)
  ) u_mult (
    .op_a      (op_a_reg),
    .op_b      (wr_word),
    .signed_op (is_signed),
    .product   (product)
  );

  mau_acc #(
    .W (2*DW)
  ) u_acc (
    .acc_in (product),
    .addend (acc_base),
    .sum    (acc_sum),
    .carry  (acc_carry)
  );

  // write decode, one select per writable register; sum extension at 0x013e has none
  always_comb begin
    sel_op_a   = 1'b0;
    sel_op_b   = 1'b0;
    sel_res_lo = 1'b0;
    sel_res_hi = 1'b0;
    sel_mode   = mode_reg;
    if (bus_wr) begin
      case (word_addr)
        `MAU_OFF_MUL_U: begin
          sel_op_a = 1'b1;
          sel_mode = mau_pkg::MAU_MUL_U;
        end
        `MAU_OFF_MUL_S: begin
          sel_op_a = 1'b1;
          sel_mode = mau_pkg::MAU_MUL_S;
        end
        `MAU_OFF_ACC_U: begin
          sel_op_a = 1'b1;
          sel_mode = mau_pkg::MAU_ACC_U;
        end
        `MAU_OFF_ACC_S: begin
          sel_op_a = 1'b1;
          sel_mode = mau_pkg::MAU_ACC_S;
        end
        `MAU_OFF_OPB: begin
          sel_op_b = 1'b1;
        end
        `MAU_OFF_RES_LO: begin
          sel_res_lo = 1'b1;
        end
        `MAU_OFF_RES_HI: begin
          sel_res_hi = 1'b1;
        end
        default: begin
          sel_op_a = 1'b0;
        end
      endcase
    end
  end

  // product or accumulation chosen by the held mode
  always_comb begin
    case (mode_reg)
      mau_pkg::MAU_MUL_U: begin
        result_word = product;
        ext_word    = `MAU_RST_WORD;
      end
      mau_pkg::MAU_MUL_S: begin
        result_word = product;
        ext_word    = product[`MAU_RES_MSB] ? `MAU_EXT_ONES : `MAU_RST_WORD;
      end
      mau_pkg::MAU_ACC_U: begin
        result_word = acc_sum;
        ext_word    = acc_carry ? `MAU_EXT_ONE : `MAU_RST_WORD;
      end
      mau_pkg::MAU_ACC_S: begin
        result_word = acc_sum;
        ext_word    = acc_sum[`MAU_RES_MSB] ? `MAU_EXT_ONES : `MAU_RST_WORD;
      end
      default: begin
        result_word = product;
        ext_word    = `MAU_RST_WORD;
      end
    endcase
  end

  // mode group
  always_comb begin
    mode_next = sel_mode;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= mau_pkg::MAU_MUL_U;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // operand group, last written values
  always_comb begin
    op_a_next = op_a_reg;
    op_b_next = op_b_reg;
    if (sel_op_a) begin
      op_a_next = wr_word;
    end
    if (sel_op_b) begin
      op_b_next = wr_word;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      op_a_reg <= `MAU_RST_WORD;
      op_b_reg <= `MAU_RST_WORD;
    end else begin
      op_a_reg <= op_a_next;
      op_b_reg <= op_b_next;
    end
  end

  // result group, preload or operation result
  always_comb begin
    res_lo_next = res_lo_reg;
    res_hi_next = res_hi_reg;
    ext_next    = ext_reg;
    if (sel_res_lo) begin
      res_lo_next = wr_word;
    end
    if (sel_res_hi) begin
      res_hi_next = wr_word;
    end
    if (sel_op_b) begin
      res_lo_next = result_word[DW-1:0];
      res_hi_next = result_word[2*DW-1:DW];
      ext_next    = ext_word;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      res_lo_reg <= `MAU_RST_WORD;
      res_hi_reg <= `MAU_RST_WORD;
      ext_reg    <= `MAU_RST_WORD;
    end else begin
      res_lo_reg <= res_lo_next;
      res_hi_reg <= res_hi_next;
      ext_reg    <= ext_next;
    end
  end

  // read mux over all mapped words
  always_comb begin
    mapped    = 1'b1;
    read_word = `MAU_RST_WORD;
    case (word_addr)
      `MAU_OFF_MUL_U: begin
        read_word = op_a_reg;
      end
      `MAU_OFF_MUL_S: begin
        read_word = op_a_reg;
      end
      `MAU_OFF_ACC_U: begin
        read_word = op_a_reg;
      end
      `MAU_OFF_ACC_S: begin
        read_word = op_a_reg;
      end
      `MAU_OFF_OPB: begin
        read_word = op_b_reg;
      end
      `MAU_OFF_RES_LO: begin
        read_word = res_lo_reg;
      end
      `MAU_OFF_RES_HI: begin
        read_word = res_hi_reg;
      end
      `MAU_OFF_SUM_EXT: begin
        read_word = ext_reg;
      end
      default: begin
        mapped    = 1'b0;
        read_word = `MAU_RST_WORD;
      end
    endcase
  end

  // read data group, zero outside a read
  always_comb begin
    rdata_next = `MAU_RST_WORD;
    if (bus_rd) begin
      rdata_next = read_word;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= `MAU_RST_WORD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // hit group, mapped reads only
  always_comb begin
    hit_next = bus_rd & mapped;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hit_reg <= 1'b0;
    end else begin
      hit_reg <= hit_next;
    end
  end

  always_comb begin
    bus_rdata = rdata_reg;
    bus_hit   = hit_reg;
  end

endmodule : mau_top

`default_nettype wire

// *** sim/mau_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module mau_props (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [15:0] bus_addr,
  input wire logic        bus_wr,
  input wire logic        bus_byte,
  input wire logic        bus_rd,
  input wire logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic        bus_hit
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [15:0] w1, w2, w3;
  always_ff @(posedge clk) begin
    w1 <= bus_wdata;
    w2 <= w1;
    w3 <= w2;
  end
  wire        [31:0] pu = {16'h0, w3} * {16'h0, w2};
  wire signed [31:0] ps = $signed(w3) * $signed(w2);
  sequence s_op(logic [15:0] o, logic [15:0] r);
    bus_wr && !bus_byte && bus_addr == o ##1
      bus_wr && !bus_byte && bus_addr == 16'h0138 ##1 bus_rd && bus_addr == r;
  endsequence
  a_mapped_hit: assert property (bus_rd && bus_addr[15:4] == 12'h013 |=> bus_hit)
    else $error("hit");
  a_quiet_bus: assert property (!(bus_rd && bus_addr[15:4] == 12'h013) |=>
    !bus_hit && bus_rdata == 16'h0) else $error("quiet");
  a_umpy_low: assert property (s_op(16'h0130, 16'h013a) |=> bus_rdata == pu[15:0])
    else $error("ulow");
  a_umpy_high: assert property (s_op(16'h0130, 16'h013c) |=> bus_rdata == pu[31:16])
    else $error("uhigh");
  a_umpy_ext: assert property (s_op(16'h0130, 16'h013e) |=> bus_rdata == 16'h0)
    else $error("uext");
  a_smpy_high: assert property (s_op(16'h0132, 16'h013c) |=> bus_rdata == ps[31:16])
    else $error("shigh");
  a_smpy_ext: assert property (s_op(16'h0132, 16'h013e) |=> bus_rdata == {16{ps[31]}})
    else $error("sext");
endmodule : mau_props
bind mau_top mau_props u_props (.clk, .arst_n, .bus_addr, .bus_wr, .bus_byte, .bus_rd,
  .bus_wdata, .bus_rdata, .bus_hit);
`default_nettype wire

// *** sim/mau_cpu.sv ***
`timescale 1ns/1ps
`default_nettype none
module mau_cpu (
  input  wire logic        clk,
  output logic      [15:0] bus_addr,
  output logic             bus_wr,
  output logic             bus_byte,
  output logic             bus_rd,
  output logic      [15:0] bus_wdata
);
  initial {bus_addr, bus_wr, bus_byte, bus_rd, bus_wdata} = '0;
  // one access a cycle; unused lines toggle
  task acc(input logic w, input logic r, input logic b, input logic [15:0] a,
    input logic [15:0] d);
    bus_wr = w;
    bus_rd = r;
    bus_byte = b;
    bus_addr = w | r ? a : ~bus_addr;
    bus_wdata = w ? d : ~bus_wdata;
    @(posedge clk);
    #1;
  endtask : acc
endmodule : mau_cpu
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, arst_n, bus_wr, bus_byte, bus_rd, bus_hit;
  logic [15:0] bus_addr, bus_wdata, bus_rdata;
  int          mismatches, total_checks;
  mau_top dut (.clk, .arst_n, .bus_addr, .bus_wr, .bus_byte, .bus_rd, .bus_wdata,
    .bus_rdata, .bus_hit);
  mau_cpu cpu (.clk, .bus_addr, .bus_wr, .bus_byte, .bus_rd, .bus_wdata);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %h %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [15:0] d, input logic b = 1'b0);
    cpu.acc(1'b1, 1'b0, b, {8'h01, a}, d);
  endtask : wr
  task rc(input logic [7:0] a, input logic [15:0] e);
    cpu.acc(1'b0, 1'b1, 1'b0, {8'h01, a}, 16'h0);
    chk(bus_rdata, e);
    chk({15'h0, bus_hit}, {15'h0, a[7:4] == 4'h3});
  endtask : rc
  task t_mul;
    logic [15:0] e[2][3];
    e = '{'{16'h0006, 16'h0001, 16'h0000}, '{16'h0006, 16'hffff, 16'hffff}};
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 3; i++) begin
        wr(8'h30 + 8'(2 * m), 16'h8003);
        wr(8'h38, 16'h0002);
        rc(8'h3a + 8'(2 * i), e[m][i]);
      end
    end
    rc(8'h36, 16'h8003);
    rc(8'h38, 16'h0002);
    $display("multiply test done");
  endtask : t_mul
  task t_acc;
    wr(8'h3a, 16'hffff);
    wr(8'h3c, 16'hffff);
    wr(8'h34, 16'h0002);
    wr(8'h38, 16'h0001);
    rc(8'h3a, 16'h0001);
    rc(8'h3e, 16'h0001);
    wr(8'h36, 16'hffff);
    wr(8'h38, 16'h0002);
    rc(8'h3c, 16'hffff);
    rc(8'h3e, 16'hffff);
    wr(8'h3e, 16'h1234);
    rc(8'h3e, 16'hffff);
    wr(8'h30, 16'h12ff, 1'b1);
    wr(8'h38, 16'hab80, 1'b1);
    rc(8'h3a, 16'h7f80);
    wr(8'h3e, 16'h1234);
    rc(8'h3e, 16'h0000);
    rc(8'h40, 16'h0000);
    $display("accumulate test done");
  endtask : t_acc
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    mismatches = 0;
    total_checks = 0;
    arst_n = 1'b0;
    repeat (8) @(posedge clk);
    #1 arst_n = 1'b1;
    t_mul();
    t_acc();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
